// >>> design/nested_vectored_irq_unit.sv
module nested_vectored_irq_unit #(
    parameter int NUM_IRQ = irq_pkg::NUM_IRQ
) (
    // Clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     rst_n,
    // Peripheral request lines, asynchronous
    input  wire logic [NUM_IRQ-1:0]       irq_line,
    // Per-line setup
    input  wire logic [NUM_IRQ-1:0]       irq_enable,
    input  wire logic [2*NUM_IRQ-1:0]     irq_priority,
    // Core handshake
    input  wire logic                     isr_enter,
    input  wire logic                     isr_exit,
    input  wire logic [5:0]               isr_exit_num,
    output logic                          irq_req,
    output logic [5:0]                    irq_exc_num
);

    ////////////////////////////////////////////////////////////////////////////////
    // Line synchronisers and edge detection.

    logic [NUM_IRQ-1:0] sync1;
    logic [NUM_IRQ-1:0] sync2;
    logic [NUM_IRQ-1:0] prev;
    logic [NUM_IRQ-1:0] edge_v;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sync1 <= '0;
            sync2 <= '0;
            prev  <= '0;
        end else begin
            sync1 <= irq_line;
            sync2 <= sync1;
            prev  <= sync2;
        end
    end

    // A pulse and the leading edge of a level look alike here, so no line needs a mode bit.
    assign edge_v = sync2 & ~prev;

    ////////////////////////////////////////////////////////////////////////////////
    // Pending and active state.

    logic [NUM_IRQ-1:0] pending;
    logic [NUM_IRQ-1:0] active;
    logic [NUM_IRQ-1:0] next_pending;
    logic [NUM_IRQ-1:0] next_active;
    logic [5:0]         enter_off;
    logic [5:0]         exit_off;
    logic [4:0]         enter_idx;
    logic [4:0]         exit_idx;
    logic               enter_ok;

    assign enter_off = irq_exc_num - irq_pkg::EXC_BASE;
    assign exit_off  = isr_exit_num - irq_pkg::EXC_BASE;
    assign enter_idx = enter_off[4:0];
    assign exit_idx  = exit_off[4:0];
    assign enter_ok  = isr_enter && irq_req;

    always_comb begin
        next_pending = pending;
        next_active  = active;
        if (isr_exit) begin
            next_active[exit_idx] = 1'b0;
            if (sync2[exit_idx]) begin
                next_pending[exit_idx] = 1'b1;
            end
        end
        if (enter_ok) begin
            next_pending[enter_idx] = 1'b0;
            next_active[enter_idx]  = 1'b1;
        end
        // New edges are applied last so that an edge never loses to a clear.
        next_pending = next_pending | edge_v;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pending <= '0;
            active  <= '0;
        end else begin
            pending <= next_pending;
            active  <= next_active;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Priority resolution.

    function automatic logic [1:0] prio_of(input logic [2*NUM_IRQ-1:0] p, input int i);
        prio_of = p[2*i +: 2];
    endfunction : prio_of

    logic [NUM_IRQ-1:0] cand;
    logic               cand_found;
    logic [2:0]         best_prio;
    logic [4:0]         best_idx;
    logic [2:0]         run_prio;
    logic [NUM_IRQ-1:0] same_prio;
    logic               next_irq_req;
    logic [5:0]         next_exc_num;

    always_comb begin
        cand = pending & irq_enable;
        if (enter_ok) begin
            cand[enter_idx] = 1'b0;
        end
        cand_found = 1'b0;
        best_prio  = irq_pkg::PRIO_IDLE;
        best_idx   = 5'h00;
        run_prio   = irq_pkg::PRIO_IDLE;
        // Walking downward with <= leaves the lowest index among equals.
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (cand[i] && ({1'b0, prio_of(irq_priority, i)} <= best_prio)) begin
                cand_found = 1'b1;
                best_prio  = {1'b0, prio_of(irq_priority, i)};
                best_idx   = 5'(i);
            end
            if (active[i] && ({1'b0, prio_of(irq_priority, i)} < run_prio)) begin
                run_prio = {1'b0, prio_of(irq_priority, i)};
            end
        end
        // The routine entered this cycle is not in active yet, but it already blocks
        // equal and less urgent lines; otherwise a same-level line would be offered
        // one cycle after each entry and the core would nest it wrongly.
        if (enter_ok && ({1'b0, prio_of(irq_priority, int'(enter_idx))} < run_prio)) begin
            run_prio = {1'b0, prio_of(irq_priority, int'(enter_idx))};
        end
        for (int j = 0; j < NUM_IRQ; j++) begin
            same_prio[j] = ({1'b0, prio_of(irq_priority, j)} == best_prio);
        end
        // Only a strictly more urgent request interrupts the running routine.
        next_irq_req = cand_found && (best_prio < run_prio);
        next_exc_num = irq_pkg::EXC_BASE + {1'b0, best_idx};
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irq_req     <= 1'b0;
            irq_exc_num <= irq_pkg::EXC_BASE;
        end else begin
            irq_req     <= next_irq_req;
            irq_exc_num <= next_exc_num;
        end
    end

    // A second view of the winning level, built per level rather than per line, so
    // the checks below do not merely repeat the resolver's own loop.
    logic [3:0] lvl_any;
    logic [2:0] top_lvl;

    always_comb begin
        lvl_any = '0;
        for (int j = 0; j < NUM_IRQ; j++) begin
            if (cand[j]) begin
                lvl_any[prio_of(irq_priority, j)] = 1'b1;
            end
        end
        top_lvl = irq_pkg::PRIO_IDLE;
        for (int l = 3; l >= 0; l--) begin
            if (lvl_any[l]) begin
                top_lvl = 3'(l);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence edge_seen_s;
        |edge_v;
    endsequence

    sequence wins_s;
        cand_found && (best_prio < run_prio);
    endsequence

    edge_sets_pend_a: assert property (
        edge_seen_s |=> ((pending & $past(edge_v)) == $past(edge_v)))
        else $error("edge did not set pending");
    req_only_enabled_a: assert property (irq_req |-> $past(|(pending & irq_enable)))
        else $error("request without enabled pending line");
    exc_in_range_a: assert property (
        irq_req |-> (irq_exc_num >= irq_pkg::EXC_BASE && irq_exc_num <= irq_pkg::EXC_LAST))
        else $error("exception number out of range");
    enter_clears_a: assert property (
        (enter_ok && !edge_v[enter_idx]) |=> !pending[$past(enter_idx)])
        else $error("pending not cleared on entry");
    enter_active_a: assert property (enter_ok |=> active[$past(enter_idx)])
        else $error("entered line not active");
    level_repend_a: assert property (
        (isr_exit && sync2[exit_idx]) |=> pending[$past(exit_idx)])
        else $error("held line not pending after exit");
    winner_shown_a: assert property (
        wins_s |=> irq_req && irq_exc_num == $past(next_exc_num))
        else $error("winning request not presented");
    best_level_a: assert property (cand_found |-> (best_prio == top_lvl))
        else $error("winner is not of the most urgent level");
    shown_not_run_a: assert property (irq_req |-> !active[enter_idx])
        else $error("line offered while its own routine runs");
    no_cand_idle_a: assert property (!cand_found |=> !irq_req)
        else $error("request without candidate");
    tie_low_idx_a: assert property (
        cand_found |-> ((cand & same_prio & ((32'h1 << best_idx) - 32'h1)) == '0))
        else $error("tie not broken to lowest index");

endmodule : nested_vectored_irq_unit

// >>> shared/irq_pkg.sv
package irq_pkg;
    localparam int          NUM_IRQ    = 32;
    localparam int          PRIO_W     = 2;
    localparam int          EXC_W      = 6;
    localparam int          IDX_W      = 5;
    localparam int          RUN_W      = 3;
    localparam logic [5:0]  EXC_BASE   = 6'h10;
    localparam logic [5:0]  EXC_LAST   = 6'h2f;
    localparam logic [2:0]  PRIO_IDLE  = 3'h4;
endpackage : irq_pkg

// >>> sim/irq_core_model.sv
module irq_core_model (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // Offer from the controller
    input  wire logic       irq_req,
    input  wire logic [5:0] irq_exc_num,
    // Bench control
    input  wire logic       go,
    input  wire logic [7:0] run_len,
    // Handshake back
    output logic            isr_enter,
    output logic            isr_exit,
    output logic [5:0]      isr_exit_num,
    output logic            busy
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [5:0] stk[$];
    int         tmr = 0;
    initial begin
        isr_enter = 1'b0;
        isr_exit = 1'b0;
        isr_exit_num = 6'h3f;
        busy = 1'b0;
    end
    // Acting two steps after the edge lets the bench's one-step changes settle first.
    always @(posedge core_clk) begin
        #2;
        isr_enter = 1'b0;
        isr_exit = 1'b0;
        // The number means nothing outside an exit, so it never rests on a stale value.
        isr_exit_num = ~isr_exit_num;
        if (!rst_n) begin
            stk.delete();
        end else if (irq_req && go) begin
            isr_enter = 1'b1;
            stk.push_back(irq_exc_num);
            tmr = run_len;
        end else if (stk.size() != 0) begin
            if (tmr == 0) begin
                isr_exit = 1'b1;
                isr_exit_num = stk.pop_back();
                tmr = run_len;
            end else begin
                tmr--;
            end
        end
        busy = (stk.size() != 0) || isr_exit;
    end
endmodule : irq_core_model

// >>> sim/nested_vectored_irq_unit_tb_top.sv
module nested_vectored_irq_unit_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [31:0] irq_line = '0;
    logic [31:0] irq_enable = '1;
    logic [63:0] irq_priority = '0;
    logic        go = 1'b1;
    logic [7:0]  run_len = 8'h04;
    logic        isr_enter, isr_exit, irq_req, busy;
    logic [5:0]  isr_exit_num, irq_exc_num;
    logic [5:0]  exits[$];
    int          n_fail = 0, n_compared = 0, n_ent[32], i;
    nested_vectored_irq_unit u_nested_vectored_irq_unit (.core_clk(core_clk), .rst_n(rst_n),
        .irq_line(irq_line), .irq_enable(irq_enable), .irq_priority(irq_priority),
        .isr_enter(isr_enter), .isr_exit(isr_exit), .isr_exit_num(isr_exit_num),
        .irq_req(irq_req), .irq_exc_num(irq_exc_num));
    irq_core_model u_irq_core_model (.core_clk(core_clk), .rst_n(rst_n), .irq_req(irq_req),
        .irq_exc_num(irq_exc_num), .go(go), .run_len(run_len), .isr_enter(isr_enter),
        .isr_exit(isr_exit), .isr_exit_num(isr_exit_num), .busy(busy));
    initial forever #4 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (isr_enter && irq_req) n_ent[irq_exc_num - 6'h10]++;
        if (isr_exit) exits.push_back(isr_exit_num);
    end
    function automatic logic [31:0] exc(input int n);
        return n + 16;
    endfunction : exc
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    task automatic pulse(input int n);
        irq_line[n] = 1'b1;
        tick(2);
        irq_line[n] = 1'b0;
    endtask : pulse
    // A level line re-arms a cycle or two after its exit, so idle must last a while.
    task automatic settle(input string name);
        int k, q;
        q = 0;
        for (k = 0; k < 3000 && q < 8; k++) begin
            tick(1);
            q = (irq_req || busy) ? 0 : q + 1;
        end
        if (k == 3000) begin
            chk("timeout", 0, 1);
            print_verdict();
        end else begin
            $display("test %s done", name);
        end
    endtask : settle
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    initial begin
        void'($urandom(32'h2a243775));
        tick(3);
        rst_n = 1'b1;
        tick(1);
        for (int k = 0; k < 8; k++) begin
            i = (k < 2) ? k * 31 : $urandom_range(31);
            irq_priority[2*i+:2] = 2'($urandom);
            n_ent = '{default: 0};
            go = 1'b0;
            pulse(i);
            tick(4);
            chk("num", exc(i), irq_exc_num);
            chk("req", 1, irq_req);
            go = 1'b1;
            settle("single");
            chk("enters", 1, n_ent[i]);
        end
        irq_enable[5] = 1'b0;
        go = 1'b0;
        pulse(5);
        tick(6);
        chk("masked", 0, irq_req);
        irq_enable[5] = 1'b1;
        tick(3);
        chk("unmasked req", 1, irq_req);
        chk("unmasked", exc(5), irq_exc_num);
        go = 1'b1;
        settle("mask");
        irq_priority = '1;
        irq_priority[18+:2] = 2'h2;
        irq_priority[8+:2] = 2'h2;
        go = 1'b0;
        pulse(9);
        pulse(4);
        tick(4);
        chk("tie", exc(4), irq_exc_num);
        irq_priority[40+:2] = 2'h0;
        pulse(20);
        tick(4);
        chk("urgent", exc(20), irq_exc_num);
        go = 1'b1;
        settle("rank");
        irq_priority = '1;
        n_ent = '{default: 0};
        run_len = 8'h28;
        pulse(7);
        tick(6);
        repeat (3) begin
            pulse(7);
            tick(2);
        end
        settle("collapse");
        chk("collapse", 2, n_ent[7]);
        run_len = 8'h0a;
        irq_line[12] = 1'b1;
        tick(60);
        irq_line[12] = 1'b0;
        settle("level");
        chk("level", 1, n_ent[12] > 2);
        chk("level stops", 1, n_ent[12] < 7);
        irq_priority[50+:2] = 2'h0;
        exits.delete();
        run_len = 8'h1e;
        pulse(3);
        tick(8);
        pulse(25);
        settle("preempt");
        chk("inner", exc(25), exits[0]);
        chk("outer", exc(3), exits[1]);
        print_verdict();
    end
endmodule : nested_vectored_irq_unit_tb_top
